//--- e3oh_map.svh
// Constants for the E3 overhead serial output link.
// Included by the package and both ends; definitions only.
`ifndef E3OH_MAP_SVH
`define E3OH_MAP_SVH
// Overhead bit positions within one frame
`define E3OH_FAW_BITS 10
`define E3OH_ALARM_POS 4'ha
`define E3OH_NATL_POS 4'hb
`define E3OH_BIP_FIRST 4'hc
`define E3OH_LAST_POS 4'hf
`define E3OH_BITS_NOBIP 12
`define E3OH_BITS_BIP 16
// Overhead clock divider: half period in system clocks (200 ns period at 25 ns)
`define E3OH_CLK_PERIOD_NS 200
`define E3OH_SYS_PERIOD_NS 25
`define E3OH_HALF_DIV ((`E3OH_CLK_PERIOD_NS / `E3OH_SYS_PERIOD_NS) / 2)
`endif

//--- e3oh_pkg.sv
// Types shared by both ends of the E3 overhead serial link.
// Assumes e3oh_map.svh is on the include path.
`include "e3oh_map.svh"
package e3oh_pkg;
  // Overhead bit index within a frame
  typedef logic [3:0] e3oh_pos_t;
  // One frame of overhead bits
  typedef struct packed {
    logic [9:0] faw;
    logic alarm;
    logic natl;
    logic [3:0] bip;
  } e3oh_frame_s;
endpackage

//--- e3oh_link_if.sv
// Interface carrying the three overhead link wires.
// Assumes the bench joins both ends through it.
`timescale 1ns/1ps
`default_nettype none
interface e3oh_link_if;
  logic overhead_bit_clock;
  logic overhead_serial_out;
  logic overhead_frame_marker;
  // Device end drives all three wires
  modport device (
    output overhead_bit_clock,
    output overhead_serial_out,
    output overhead_frame_marker
  );
  // Terminal end only listens
  modport terminal (
    input overhead_bit_clock,
    input overhead_serial_out,
    input overhead_frame_marker
  );
endinterface
`default_nettype wire

//--- e3oh_device.sv
// Device end: shifts the latest held frame's overhead bits out on a divided clock; a frame overwritten while waiting is dropped.
// Assumes frame_valid_in pulses once per frame with frame_in on sys_clk_in.
// Assumes the far end samples the link on the rise of the divided clock.
`timescale 1ns/1ps
`default_nettype none
`include "e3oh_map.svh"
module e3oh_device #(
  parameter int HALF_DIV = `E3OH_HALF_DIV
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Frame source
  input wire e3oh_pkg::e3oh_frame_s frame_in,
  input wire logic frame_valid_in,
  input wire logic bip_enable_in,
  // Link
  e3oh_link_if.device link,
  // Status
  output logic busy_out
);
  import e3oh_pkg::*;

  // Refuse divider settings the 8-bit counter cannot serve
  if (HALF_DIV < 1 || HALF_DIV > 255) begin : g_bad_half_div
    $error("HALF_DIV must lie between 1 and 255");
  end

  typedef enum logic [1:0] {
    E3OH_IDLE = 2'b00,
    E3OH_SEND = 2'b01
  } e3oh_state_e;

  // Divider state
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic ohclk;
  logic next_ohclk;
  logic fall;
  // Holding slot for the latest received frame
  logic [15:0] pend;
  logic [15:0] next_pend;
  logic pend_valid;
  logic next_pend_valid;
  logic pend_bip;
  logic next_pend_bip;
  logic launch;
  // Serialiser state
  e3oh_state_e state;
  e3oh_state_e next_state;
  logic [15:0] shreg;
  logic [15:0] next_shreg;
  logic cur_bip;
  logic next_cur_bip;
  e3oh_pos_t pos;
  e3oh_pos_t next_pos;
  logic sdata;
  logic next_sdata;
  logic marker;
  logic next_marker;
  logic busy;
  logic next_busy;
  logic last_bit;

  // Free running overhead clock, HALF_DIV low then HALF_DIV high
  always_comb begin
    next_div_cnt = div_cnt + 8'h01;
    next_ohclk = ohclk;
    if (div_cnt == 8'(HALF_DIV - 1)) begin
      next_div_cnt = 8'h00;
      next_ohclk = ~ohclk;
    end
  end

  // Divider registers
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt <= 8'h00;
      ohclk <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      ohclk <= next_ohclk;
    end
  end

  // Clock about to fall: the only instant data and marker move
  assign fall = ohclk && (div_cnt == 8'(HALF_DIV - 1));
  // Start at a fall while idle; a frame landing now waits one period
  assign launch = fall && (state == E3OH_IDLE) && pend_valid && !frame_valid_in;

  // Holding slot: a newer frame overwrites one not yet launched
  always_comb begin
    next_pend = pend;
    next_pend_valid = pend_valid;
    next_pend_bip = pend_bip;
    if (frame_valid_in) begin
      next_pend = frame_in;
      next_pend_valid = 1'b1;
      next_pend_bip = bip_enable_in;
    end else if (launch) begin
      next_pend_valid = 1'b0;
    end
  end

  // Holding slot registers
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend <= 16'h0000;
      pend_valid <= 1'b0;
      pend_bip <= 1'b0;
    end else begin
      pend <= next_pend;
      pend_valid <= next_pend_valid;
      pend_bip <= next_pend_bip;
    end
  end

  // Final position: national bit, or last BIP-4 bit when enabled
  assign last_bit = (pos == (cur_bip ? `E3OH_LAST_POS : `E3OH_NATL_POS));

  // Serialiser: marker with the first bit, then one bit per link period
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_cur_bip = cur_bip;
    next_pos = pos;
    next_sdata = sdata;
    next_marker = marker;
    next_busy = busy;
    if (fall) begin
      case (state)
        E3OH_IDLE: begin
          // Data and marker rest low between frames
          next_marker = 1'b0;
          next_sdata = 1'b0;
          if (launch) begin
            next_state = E3OH_SEND;
            next_sdata = pend[15];
            next_shreg = {pend[14:0], 1'b0};
            next_cur_bip = pend_bip;
            next_pos = 4'h0;
            next_marker = 1'b1;
            next_busy = 1'b1;
          end
        end
        E3OH_SEND: begin
          // Marker lasts exactly the first bit's period
          next_marker = 1'b0;
          if (last_bit) begin
            next_state = E3OH_IDLE;
            next_sdata = 1'b0;
            next_busy = 1'b0;
          end else begin
            // Word, alarm, national, then BIP-4 in fixed order
            next_pos = pos + 4'h1;
            next_sdata = shreg[15];
            next_shreg = {shreg[14:0], 1'b0};
          end
        end
        default: begin
          next_state = E3OH_IDLE;
          next_marker = 1'b0;
          next_sdata = 1'b0;
          next_busy = 1'b0;
        end
      endcase
    end
  end

  // Serialiser registers
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= E3OH_IDLE;
      shreg <= 16'h0000;
      cur_bip <= 1'b0;
      pos <= 4'h0;
      sdata <= 1'b0;
      marker <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      cur_bip <= next_cur_bip;
      pos <= next_pos;
      sdata <= next_sdata;
      marker <= next_marker;
      busy <= next_busy;
    end
  end

  // Link pins straight from flip-flops
  assign link.overhead_bit_clock = ohclk;
  assign link.overhead_serial_out = sdata;
  assign link.overhead_frame_marker = marker;
  // Status straight from its flip-flop
  assign busy_out = busy;
endmodule
`default_nettype wire

//--- e3oh_terminal.sv
// Terminal end: samples the overhead link and rebuilds each frame's bits.
// Assumes the link clock is asynchronous to sys_clk_in and much slower.
`timescale 1ns/1ps
`default_nettype none
`include "e3oh_map.svh"
module e3oh_terminal (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Link
  e3oh_link_if.terminal link,
  // Configuration
  input wire logic bip_enable_in,
  // Recovered frame
  output e3oh_pkg::e3oh_frame_s frame_out,
  output logic frame_valid_out
);
  import e3oh_pkg::*;

  logic [1:0] clk_sync, data_sync, mark_sync;
  logic clk_prev, next_clk_prev;
  logic rise;
  logic [15:0] shreg, next_shreg;
  e3oh_pos_t cnt, next_cnt;
  logic locked, next_locked;
  e3oh_frame_s frame, next_frame;
  logic valid, next_valid;
  e3oh_pos_t last_pos;

  // Two-stage synchronisers for the link wires
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_sync <= 2'b00;
      data_sync <= 2'b00;
      mark_sync <= 2'b00;
    end else begin
      clk_sync <= {clk_sync[0], link.overhead_bit_clock};
      data_sync <= {data_sync[0], link.overhead_serial_out};
      mark_sync <= {mark_sync[0], link.overhead_frame_marker};
    end
  end

  // Rising edge of the overhead clock, seen on settled copies
  assign rise = clk_sync[1] && !clk_prev;
  assign last_pos = bip_enable_in ? `E3OH_LAST_POS : `E3OH_NATL_POS;

  // Edge counting and bit assembly
  always_comb begin
    next_clk_prev = clk_sync[1];
    next_shreg = shreg;
    next_cnt = cnt;
    next_locked = locked;
    next_frame = frame;
    next_valid = 1'b0;
    if (rise) begin
      if (mark_sync[1]) begin
        // Marker restarts the count at zero
        next_cnt = 4'h0;
        next_locked = 1'b1;
        next_shreg = {data_sync[1], 15'h0000};
      end else if (locked) begin
        // Count rising edges since the marker
        next_cnt = cnt + 4'h1;
        next_shreg = shreg | (16'h8000 >> (cnt + 4'h1));
        next_shreg = data_sync[1] ? next_shreg : (shreg & ~(16'h8000 >> (cnt + 4'h1)));
      end
      if ((mark_sync[1] ? 4'h0 : cnt + 4'h1) == last_pos && (locked || mark_sync[1])) begin
        // BIP-4 positions kept only when enabled
        next_frame = bip_enable_in ? next_shreg : {next_shreg[15:4], 4'h0};
        next_valid = 1'b1;
        next_locked = 1'b0;
      end
    end
  end

  // State registers
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_prev <= 1'b0;
      shreg <= 16'h0000;
      cnt <= 4'h0;
      locked <= 1'b0;
      frame <= '0;
      valid <= 1'b0;
    end else begin
      clk_prev <= next_clk_prev;
      shreg <= next_shreg;
      cnt <= next_cnt;
      locked <= next_locked;
      frame <= next_frame;
      valid <= next_valid;
    end
  end

  assign frame_out = frame;
  assign frame_valid_out = valid;
endmodule
`default_nettype wire

//--- e3oh_link_properties.sv
// Timing checks on the three overhead link wires.
// Assumes it sits beside the link interface, sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "e3oh_map.svh"
module e3oh_link_properties #(
  parameter int HALF_DIV = `E3OH_HALF_DIV
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Link wires
  input wire logic overhead_bit_clock,
  input wire logic overhead_serial_out,
  input wire logic overhead_frame_marker
);
  localparam int HD = HALF_DIV;
  localparam int P = 2 * HALF_DIV;
  localparam int P1 = P - 1;
  localparam int GAP = 12 * P - 2;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // Marker stays up for one whole link period
  sequence s_mark_hold;
    overhead_frame_marker throughout ##P1 1'b1;
  endsequence
  property p_clk_period;
    $changed(overhead_bit_clock) |-> ##HD $changed(overhead_bit_clock);
  endproperty
  property p_clk_steady;
    $changed(overhead_bit_clock) |=> $stable(overhead_bit_clock);
  endproperty
  property p_clk_live;
    1'b1 |-> ##[1:P] $changed(overhead_bit_clock);
  endproperty
  property p_data_on_fall;
    $changed(overhead_serial_out) |-> $fell(overhead_bit_clock);
  endproperty
  property p_mark_on_fall;
    $changed(overhead_frame_marker) |-> $fell(overhead_bit_clock);
  endproperty
  property p_mark_width;
    $rose(overhead_frame_marker) |-> s_mark_hold ##1 !overhead_frame_marker;
  endproperty
  property p_mark_sampled;
    $rose(overhead_frame_marker) |-> ##HD ($rose(overhead_bit_clock) && overhead_frame_marker);
  endproperty
  property p_frame_gap;
    $rose(overhead_frame_marker) |=> !$rose(overhead_frame_marker) throughout ##GAP 1'b1;
  endproperty
  a_clk_period: assert property (p_clk_period) else $error("link clock half period wrong");
  a_clk_steady: assert property (p_clk_steady) else $error("link clock glitch");
  a_clk_live: assert property (p_clk_live) else $error("link clock stopped");
  a_data_on_fall: assert property (p_data_on_fall) else $error("data moved off fall");
  a_mark_on_fall: assert property (p_mark_on_fall) else $error("marker moved off fall");
  a_mark_width: assert property (p_mark_width) else $error("marker width wrong");
  a_mark_sampled: assert property (p_mark_sampled) else $error("marker missed rise");
  a_frame_gap: assert property (p_frame_gap) else $error("frame too short");
endmodule
`default_nettype wire

//--- tb_e3_overhead_serial_output_clocked.sv
// Bench joining device and terminal ends over one link.
// Assumes map, package and interface files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_e3_overhead_serial_output_clocked;
  import e3oh_pkg::*;
  localparam int HD = 2;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [15:0] frame_in = '0;
  logic frame_valid_in = 1'b0;
  logic bip_en = 1'b0;
  e3oh_frame_s frame_out;
  logic frame_valid_out;
  logic busy;
  logic [15:0] wword = '0;
  logic [15:0] wlast = '0;
  int wcnt = 16;
  int mismatches = 0;
  int checks = 0;
  logic [15:0] pats [4] = '{16'ha5c3, 16'h5a3c, 16'h8000, 16'h0001};
  e3oh_link_if lnk ();
  e3oh_device #(.HALF_DIV(HD)) i_e3oh_device (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .frame_in(frame_in), .frame_valid_in(frame_valid_in), .bip_enable_in(bip_en),
    .link(lnk), .busy_out(busy));
  e3oh_terminal i_e3oh_terminal (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .link(lnk),
    .bip_enable_in(bip_en), .frame_out(frame_out), .frame_valid_out(frame_valid_out));
  e3oh_link_properties #(.HALF_DIV(HD)) i_e3oh_link_properties (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .overhead_bit_clock(lnk.overhead_bit_clock),
    .overhead_serial_out(lnk.overhead_serial_out),
    .overhead_frame_marker(lnk.overhead_frame_marker));
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  // Wire view: rebuild each frame from rising link clock edges
  always @(posedge lnk.overhead_bit_clock) begin
    if (lnk.overhead_frame_marker === 1'b1) begin
      wword = '0;
      wcnt = 0;
    end
    if (wcnt < 16) begin
      wword[15 - wcnt] = lnk.overhead_serial_out;
      wcnt++;
      if (wcnt == (bip_en ? 16 : 12)) wlast = wword;
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle frame pulse
  task automatic send(input logic [15:0] f);
    @(negedge sys_clk_in);
    frame_in = f;
    frame_valid_in = 1'b1;
    @(negedge sys_clk_in);
    frame_valid_in = 1'b0;
  endtask
  // Wait for the recovered frame, compare it and the wire view
  task automatic expect_frame(input logic [15:0] f);
    logic [15:0] e;
    int i;
    e = bip_en ? f : {f[15:4], 4'h0};
    i = 0;
    while (frame_valid_out !== 1'b1 && i < 400) begin
      @(negedge sys_clk_in);
      i++;
    end
    check("valid", {15'h0, frame_valid_out}, 16'h1);
    check("frame_out", frame_out, e);
    check("wire", wlast, e);
    @(negedge sys_clk_in);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    repeat (2) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    // Patterns with BIP-4 off and on in turn
    foreach (pats[k]) begin
      bip_en = k[0];
      send(pats[k]);
      expect_frame(pats[k]);
    end
    // Frames arriving mid-shift: latest one wins
    send(16'h1234);
    repeat (6) @(negedge sys_clk_in);
    check("busy", {15'h0, busy}, 16'h1);
    send(16'hbeef);
    send(16'hc0de);
    expect_frame(16'h1234);
    expect_frame(16'hc0de);
    // Reset in mid-frame, then recover
    send(16'hffff);
    repeat (12) @(negedge sys_clk_in);
    nrst_in = 1'b0;
    @(negedge sys_clk_in);
    check("reset", {11'h0, busy, frame_valid_out, lnk.overhead_bit_clock,
      lnk.overhead_serial_out, lnk.overhead_frame_marker}, 16'h0);
    nrst_in = 1'b1;
    bip_en = 1'b0;
    send(16'h7ff5);
    expect_frame(16'h7ff5);
    results();
  end
endmodule
`default_nettype wire
